/* core/ssp_shadow_engine.sv */
// Shadow register command engine for PIO and queued DMA transfers
// How it works
// - Command write sets busy and sends the shadow contents as a command frame.
// - Read-direction PIO setup is held aside; shadow registers stay untouched.
// - Data frame with held setup loads shadow: request set, busy clear, maybe interrupt.
// - Incoming PIO words enter receive FIFO; data register reads pop its head.
// - Receive ready drops while the receive FIFO is full.
// - After setup's word count is read, ending status loads, request clears.
// - Write-direction setup loads beginning status at once, may interrupt.
// - Data register writes feed transmit FIFO; link sees valid only when nonempty.
// - After setup's count is pushed, final status loads and frame end is marked.
// - Final status taken as given, engine returns to its just-issued state.
// - Device bits frame sets service request; interrupt only when not busy.
// - Early DMA read data fills receive FIFO, then flow control holds it.
// - Data frame without held setup goes to the DMA engine.
// - Each outgoing DMA frame needs its own activation first.
// - Outgoing DMA total equals the programmed transfer count.
// - Activation before DMA is programmed is kept and starts it later.
// - Register frame loads status; interrupt follows its header flag.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_shadow_engine
  import ssp_pkg::*;
#(
  parameter int DEPTH       = `SSP_FIFO_DEPTH,
  parameter int FRAME_WORDS = `SSP_FRAME_WORDS
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             intrq,
  output logic             cmd_fis_valid,
  output ssp_h2d_s         cmd_fis,
  input  wire logic        cmd_fis_ready,
  input  wire logic        rx_fis_valid,
  input  wire ssp_fis_s    rx_fis,
  input  wire logic        rx_data_valid,
  input  wire logic [15:0] rx_data,
  output logic             rx_data_ready,
  output logic             tx_data_valid,
  output ssp_word_s        tx_data,
  input  wire logic        tx_data_ready,
  input  wire logic        dma_src_valid,
  input  wire logic [15:0] dma_src_data,
  output logic             dma_src_ready,
  output logic             dma_snk_valid,
  output logic      [15:0] dma_snk_data,
  input  wire logic        dma_snk_ready
);
  ssp_state_e  state_r;
  logic [7:0]  status_r;
  logic [7:0]  feat_r;
  logic [15:0] seccnt_r;
  logic        held_r;
  ssp_fis_s    held_fis_r;
  logic        to_dma_r;
  logic        run_r;
  logic        todev_r;
  logic        act_pend_r;
  logic        intrq_r;
  logic        cmd_valid_r;
  ssp_h2d_s    cmd_fis_r;
  logic [15:0] rdata_r;
  logic [15:0] pio_cnt;
  logic        pio_one;
  logic [15:0] dma_cnt;
  logic        dma_zero;
  logic [15:0] frm_cnt;
  logic        frm_one;
  logic        rx_full;
  logic        rx_empty;
  logic [15:0] rx_head;
  logic        tx_full;
  logic        tx_empty;
  ssp_word_s   tx_din;

  // Register port decode
  logic wr_data, wr_cmd, rd_data, rd_stat;
  assign wr_data = reg_wr && (reg_addr == `SSP_OFF_DATA);
  assign wr_cmd  = reg_wr && (reg_addr == `SSP_OFF_STATCMD);
  assign rd_data = reg_rd && (reg_addr == `SSP_OFF_DATA);
  assign rd_stat = reg_rd && (reg_addr == `SSP_OFF_STATCMD);
  // Frame events from the transport side
  logic ev_setup, ev_data, ev_reg, ev_sdb, ev_act;
  assign ev_setup = rx_fis_valid && (rx_fis.kind == FIS_PIO_SETUP);
  assign ev_data  = rx_fis_valid && (rx_fis.kind == FIS_DATA);
  assign ev_reg   = rx_fis_valid && (rx_fis.kind == FIS_REG_D2H);
  assign ev_sdb   = rx_fis_valid && (rx_fis.kind == FIS_SDB);
  assign ev_act   = rx_fis_valid && (rx_fis.kind == FIS_DMA_ACT);
  logic setup_in, setup_out, pio_start;
  assign setup_in  = ev_setup && !rx_fis.to_dev;
  assign setup_out = ev_setup && rx_fis.to_dev;
  assign pio_start = ev_data && held_r;
  // Data movement strobes
  logic pio_pop, pio_push, snk_xfer, src_xfer, pio_in_done, pio_out_done, dma_go, dma_done;
  assign pio_pop      = rd_data && (state_r == ST_PIO_IN) && !rx_empty;
  assign pio_push     = wr_data && (state_r == ST_PIO_OUT) && !tx_full;
  assign snk_xfer     = dma_snk_valid && dma_snk_ready;
  assign src_xfer     = dma_src_valid && dma_src_ready;
  assign pio_in_done  = pio_pop && pio_one;
  assign pio_out_done = pio_push && pio_one;
  assign dma_go       = (state_r == ST_IDLE) && act_pend_r && run_r && todev_r
                        && !dma_zero && !ev_reg;
  assign dma_done     = src_xfer && frm_one;

  // Early DMA data waits in the FIFO until the engine runs
  assign rx_data_ready = !rx_full && ((state_r == ST_PIO_IN) || to_dma_r);
  assign dma_snk_valid = to_dma_r && run_r && !rx_empty;
  assign dma_snk_data  = rx_head;
  assign dma_src_ready = (state_r == ST_DMA_OUT) && !tx_full;
  assign tx_data_valid = !tx_empty;
  assign tx_din.data   = (state_r == ST_DMA_OUT) ? dma_src_data : reg_wdata;
  assign tx_din.last   = (state_r == ST_DMA_OUT) ? frm_one : pio_one;
  assign intrq         = intrq_r;
  assign cmd_fis_valid = cmd_valid_r;
  assign cmd_fis       = cmd_fis_r;
  assign reg_rdata     = rdata_r;

  ssp_fifo #(.W(16), .DEPTH(DEPTH)) u_rx_fifo (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .push(rx_data_valid && rx_data_ready), .din(rx_data), .pop(pio_pop || snk_xfer), .dout(rx_head),
    .full(rx_full), .empty(rx_empty));
  ssp_fifo #(.W(17), .DEPTH(DEPTH)) u_tx_fifo (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .push(pio_push || src_xfer), .din(tx_din), .pop(tx_data_valid && tx_data_ready), .dout(tx_data),
    .full(tx_full), .empty(tx_empty));
  ssp_cnt #(.W(16)) u_pio_cnt (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .load(pio_start || setup_out),
    .ld_val(pio_start ? held_fis_r.count : rx_fis.count), .dec(pio_pop || pio_push), .value(pio_cnt),
    .one(pio_one), .zero());
  // Whole-transfer count; each cycle that moves a word either way takes one off, stopping at zero
  ssp_cnt #(.W(16)) u_dma_cnt (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .load(reg_wr && (reg_addr == `SSP_OFF_DMA_CNT)), .ld_val(reg_wdata),
    .dec(snk_xfer || src_xfer), .value(dma_cnt), .one(), .zero(dma_zero));
  // One frame per activation, capped so a frame stays bounded
  ssp_cnt #(.W(16)) u_frm_cnt (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .load(dma_go),
    .ld_val((dma_cnt > 16'(FRAME_WORDS)) ? 16'(FRAME_WORDS) : dma_cnt), .dec(src_xfer),
    .value(frm_cnt), .one(frm_one), .zero());

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else if (ce)
    begin
      if (ev_reg)
        state_r <= ST_IDLE;
      else
        unique case (state_r)
          ST_IDLE:
          begin
            if (pio_start)
              state_r <= ST_PIO_IN;
            else if (setup_out)
              state_r <= ST_PIO_OUT;
            else if (dma_go)
              state_r <= ST_DMA_OUT;
          end
          ST_PIO_IN:  if (pio_in_done) state_r <= ST_IDLE;
          ST_PIO_OUT: if (pio_out_done) state_r <= ST_IDLE;
          ST_DMA_OUT: if (dma_done) state_r <= ST_IDLE;
        endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      held_r     <= 1'b0;
      held_fis_r <= '0;
    end
    else if (ce)
    begin
      if (ev_setup)
      begin
        held_r     <= !rx_fis.to_dev;
        held_fis_r <= rx_fis;
      end
      else if (pio_in_done || ev_reg)
        held_r <= 1'b0;
    end
  end

  // Shadow status and sector count
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      status_r <= `SSP_RST_STATUS;
      seccnt_r <= '0;
    end
    else if (ce)
    begin
      if (ev_reg)
      begin
        status_r <= rx_fis.status;
        seccnt_r <= rx_fis.count;
      end
      else if (pio_start)
      begin
        status_r                    <= held_fis_r.status;
        status_r[`SSP_BIT_DATA_REQ] <= 1'b1;
        status_r[`SSP_BIT_BUSY]     <= 1'b0;
        seccnt_r                    <= held_fis_r.count;
      end
      else if (setup_out)
      begin
        status_r                    <= rx_fis.status;
        status_r[`SSP_BIT_DATA_REQ] <= 1'b1;
        status_r[`SSP_BIT_BUSY]     <= 1'b0;
      end
      else if (pio_in_done || pio_out_done)
      begin
        status_r                    <= held_fis_r.end_status;
        status_r[`SSP_BIT_DATA_REQ] <= 1'b0;
      end
      else if (ev_sdb)
        status_r[`SSP_BIT_SERVICE_REQ] <= 1'b1;
      else if (wr_cmd)
        status_r[`SSP_BIT_BUSY] <= 1'b1;
      else if (reg_wr && (reg_addr == `SSP_OFF_SECCNT))
        seccnt_r <= reg_wdata;
    end
  end

  // Interrupt line is a level, cleared by a status read; a new event wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      intrq_r <= 1'b0;
    else if (ce)
    begin
      if ((ev_reg && rx_fis.irq)
          || (pio_start && held_fis_r.irq)
          || (setup_out && rx_fis.irq)
          || (ev_sdb && !status_r[`SSP_BIT_BUSY]))
        intrq_r <= 1'b1;
      else if (rd_stat)
        intrq_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cmd_valid_r <= 1'b0;
      cmd_fis_r   <= '0;
    end
    else if (ce)
    begin
      if (wr_cmd)
      begin
        cmd_valid_r <= 1'b1;
        cmd_fis_r   <= '{command: reg_wdata[7:0], features: feat_r, seccnt: seccnt_r};
      end
      else if (cmd_fis_ready)
        cmd_valid_r <= 1'b0;
    end
  end

  // DMA routing and activation memory
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      to_dma_r   <= 1'b0;
      act_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      if (ev_data && !held_r)
        to_dma_r <= 1'b1;
      else if (ev_reg)
        to_dma_r <= 1'b0;
      if (ev_act)
        act_pend_r <= 1'b1;
      else if (dma_go || ev_reg)
        act_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      feat_r  <= '0;
      run_r   <= 1'b0;
      todev_r <= 1'b0;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == `SSP_OFF_FEAT)
        feat_r <= reg_wdata[7:0];
      if (reg_addr == `SSP_OFF_DMA_CTRL)
      begin
        run_r   <= reg_wdata[`SSP_BIT_RUN];
        todev_r <= reg_wdata[`SSP_BIT_TODEV];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_r <= '0;
    else if (ce)
    begin
      rdata_r <= '0;
      if (reg_rd)
        unique case (reg_addr)
          `SSP_OFF_DATA:     rdata_r <= pio_pop ? rx_head : 16'h0000;
          `SSP_OFF_FEAT:     rdata_r <= {8'h00, feat_r};
          `SSP_OFF_SECCNT:   rdata_r <= seccnt_r;
          `SSP_OFF_STATCMD:  rdata_r <= {8'h00, status_r};
          `SSP_OFF_DMA_CTRL: rdata_r <= {14'h0000, todev_r, run_r};
          `SSP_OFF_DMA_CNT:  rdata_r <= dma_cnt;
          default:           rdata_r <= 16'h0000;
        endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_cmd_busy: assert property (ce && wr_cmd && !rx_fis_valid |=> status_r[`SSP_BIT_BUSY]
                               && cmd_fis_valid)
    else $error("command write did not set busy and send frame");
  a_setup_hold: assert property (ce && setup_in |=> held_r && $stable(status_r))
    else $error("held setup changed shadow status");
  a_data_load: assert property (ce && pio_start && !ev_reg |=> status_r[`SSP_BIT_DATA_REQ]
                                && !status_r[`SSP_BIT_BUSY] && state_r == ST_PIO_IN)
    else $error("data frame did not load held setup");
  a_rx_flow: assert property (rx_full |-> !rx_data_ready)
    else $error("receive accepted while full");
  a_pio_in_end: assert property (ce && pio_in_done && !rx_fis_valid |=>
                                 !status_r[`SSP_BIT_DATA_REQ] && !held_r)
    else $error("read block end not applied");
  a_out_setup: assert property (ce && setup_out && state_r == ST_IDLE |=>
                                status_r[`SSP_BIT_DATA_REQ] && state_r == ST_PIO_OUT)
    else $error("write setup not loaded");
  a_tx_last: assert property (ce && pio_out_done && !rx_fis_valid |=>
                              !status_r[`SSP_BIT_DATA_REQ] && !tx_empty)
    else $error("write block end not applied");
  a_sdb_service_request_flag: assert property (ce && ev_sdb && !pio_start && !setup_out && !pio_in_done && !pio_out_done
                               |=> status_r[`SSP_BIT_SERVICE_REQ] && (intrq || $past(status_r[`SSP_BIT_BUSY])))
    else $error("device bits frame lost");
  a_sdb_quiet: assert property (ce && ev_sdb && status_r[`SSP_BIT_BUSY] && !intrq |=> !intrq)
    else $error("device bits frame interrupted an active command");
  a_dma_gate: assert property (state_r == ST_DMA_OUT && $past(state_r) != ST_DMA_OUT
                               |-> $past(act_pend_r) && run_r && todev_r)
    else $error("DMA frame started without activation");
  a_dma_early: assert property (to_dma_r && !run_r |-> (rx_data_ready == !rx_full) && !dma_snk_valid)
    else $error("DMA data not held back before context restored");

  c_pio_read: cover property (pio_in_done);
  c_pio_write: cover property (pio_out_done);
  c_dma_frame: cover property (dma_done);
  c_rx_held: cover property (rx_full && to_dma_r && !run_r);
endmodule
`default_nettype wire

/* include/ssp_params.svh */
// Register offsets, status bit positions and sizing constants
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_OFF_DATA     4'h0
`define SSP_OFF_FEAT     4'h1
`define SSP_OFF_SECCNT   4'h2
`define SSP_OFF_STATCMD  4'h7
`define SSP_OFF_DMA_CTRL 4'h8
`define SSP_OFF_DMA_CNT  4'h9
`define SSP_BIT_BUSY        7
`define SSP_BIT_SERVICE_REQ 4
`define SSP_BIT_DATA_REQ    3
`define SSP_BIT_BUS_RELEASE 2
`define SSP_BIT_RUN      0
`define SSP_BIT_TODEV    1
`define SSP_RST_STATUS   8'h00
`define SSP_FIFO_DEPTH   16
`define SSP_FRAME_WORDS  4096
`endif

/* include/ssp_pkg.sv */
// Types shared by the shadow register engine
package ssp_pkg;
  typedef enum logic [2:0] {
    FIS_REG_D2H   = 3'b000,
    FIS_PIO_SETUP = 3'b001,
    FIS_DATA      = 3'b010,
    FIS_SDB       = 3'b011,
    FIS_DMA_ACT   = 3'b100
  } ssp_fis_e;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PIO_IN  = 2'b01,
    ST_PIO_OUT = 2'b10,
    ST_DMA_OUT = 2'b11
  } ssp_state_e;
  typedef struct packed {
    ssp_fis_e    kind;
    logic        irq;
    logic        to_dev;
    logic [7:0]  status;
    logic [7:0]  end_status;
    logic [15:0] count;
  } ssp_fis_s;
  typedef struct packed {
    logic [7:0]  command;
    logic [7:0]  features;
    logic [15:0] seccnt;
  } ssp_h2d_s;
  typedef struct packed {
    logic [15:0] data;
    logic        last;
  } ssp_word_s;
endpackage

/* core/ssp_fifo.sv */
// Speed-matching FIFO in flip-flops
`timescale 1ns/10ps
`default_nettype none
module ssp_fifo
  import ssp_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 16
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  input  wire logic         pop,
  output logic      [W-1:0] dout,
  output logic              full,
  output logic              empty
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;

  assign empty = (wp_r == rp_r);
  assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign dout  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (ce && push && !full)
      mem_r[wp_r[AW-1:0]] <= din;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else if (ce)
    begin
      if (push && !full)
        wp_r <= wp_r + 1'b1;
      if (pop && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* core/ssp_cnt.sv */
// Loadable down counter for word counts
`timescale 1ns/10ps
`default_nettype none
module ssp_cnt
  import ssp_pkg::*;
#(
  parameter int W = 16
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] ld_val,
  input  wire logic         dec,
  output logic      [W-1:0] value,
  output logic              one,
  output logic              zero
);
  assign one  = (value == W'(1));
  assign zero = (value == '0);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      value <= '0;
    else if (ce)
    begin
      if (load)
        value <= ld_val;
      else if (dec && !zero)
        value <= value - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/ssp_drive_model.sv */
// Behavioural drive: frame headers, receive words, transmit sink
`timescale 1ns/10ps
`default_nettype none
module ssp_drive_model
  import ssp_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      slow,
  input  wire logic      cmd_fis_valid,
  input  wire ssp_h2d_s  cmd_fis,
  output logic           cmd_fis_ready,
  output logic           rx_fis_valid,
  output ssp_fis_s       rx_fis,
  output logic           rx_data_valid,
  output logic    [15:0] rx_data,
  input  wire logic      rx_data_ready,
  input  wire logic      tx_data_valid,
  input  wire ssp_word_s tx_data,
  output logic           tx_data_ready
);
  ssp_h2d_s  cmd_q[$];
  ssp_word_s tx_q[$];
  initial
  begin
    cmd_fis_ready = 1'b0;
    rx_fis_valid  = 1'b0;
    rx_fis        = '0;
    rx_data_valid = 1'b0;
    rx_data       = 16'h5A5A;
    tx_data_ready = 1'b0;
  end
  // Slow mode stalls every other cycle to exercise the FIFO drain side
  always @(posedge ref_clk)
  begin
    tx_data_ready <= !slow || !tx_data_ready;
    cmd_fis_ready <= tx_data_ready;
    if (tx_data_valid && tx_data_ready)
      tx_q.push_back(tx_data);
    if (cmd_fis_valid && cmd_fis_ready)
      cmd_q.push_back(cmd_fis);
  end
  task automatic hdr(input ssp_fis_s f);
    @(posedge ref_clk);
    rx_fis_valid <= 1'b1;
    rx_fis       <= f;
    @(posedge ref_clk);
    rx_fis_valid <= 1'b0;
    rx_fis       <= ~f;
  endtask
  task automatic send(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++)
    begin
      rx_data_valid <= 1'b1;
      rx_data       <= base + 16'(i);
      @(posedge ref_clk iff rx_data_ready);
    end
    rx_data_valid <= 1'b0;
    rx_data       <= ~rx_data;
  endtask
endmodule
`default_nettype wire

/* bench/ssp_shadow_engine_test.sv */
// Self-checking bench for the shadow register engine
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_shadow_engine_test
  import ssp_pkg::*;
;
  logic        ref_clk, rst_n, reg_wr, reg_rd, intrq, slow;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_data, dma_src_data, dma_snk_data;
  logic        cmd_fis_valid, cmd_fis_ready, rx_fis_valid, rx_data_valid;
  logic        rx_data_ready, tx_data_valid, tx_data_ready;
  logic        dma_src_valid, dma_src_ready, dma_snk_valid, dma_snk_ready;
  ssp_h2d_s    cmd_fis;
  ssp_fis_s    rx_fis;
  ssp_word_s   tx_data;
  logic [15:0] snk_q[$];
  int          error_cnt, n_checks, cyc;
  ssp_shadow_engine #(.DEPTH(4), .FRAME_WORDS(4)) u_dut (
    .ref_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .intrq, .cmd_fis_valid, .cmd_fis, .cmd_fis_ready,
    .rx_fis_valid, .rx_fis, .rx_data_valid, .rx_data, .rx_data_ready,
    .tx_data_valid, .tx_data, .tx_data_ready, .dma_src_valid, .dma_src_data,
    .dma_src_ready, .dma_snk_valid, .dma_snk_data, .dma_snk_ready);
  ssp_drive_model u_drv (
    .ref_clk, .slow, .cmd_fis_valid, .cmd_fis, .cmd_fis_ready, .rx_fis_valid,
    .rx_fis, .rx_data_valid, .rx_data, .rx_data_ready, .tx_data_valid,
    .tx_data, .tx_data_ready);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Host memory side: source counts up, sink records
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (dma_src_valid && dma_src_ready)
      dma_src_data <= dma_src_data + 16'h0001;
    if (dma_snk_valid && dma_snk_ready)
      snk_q.push_back(dma_snk_data);
    if (cyc == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  function automatic ssp_fis_s fis(ssp_fis_e k, logic q, logic td, logic [7:0] st, logic [15:0] n);
    return '{k, q, td, st, 8'h80, n};
  endfunction
  task automatic t_pio_read;
    wr(`SSP_OFF_FEAT, 16'h0012);
    wr(`SSP_OFF_SECCNT, 16'h0004);
    wr(`SSP_OFF_STATCMD, 16'h0020);
    rd_chk("busy", `SSP_OFF_STATCMD, 16'h0080);
    chk("cmd", {8'h00, u_drv.cmd_q[0].command}, 16'h0020);
    chk("seccnt", u_drv.cmd_q[0].seccnt, 16'h0004);
    chk("feat", {8'h00, u_drv.cmd_q[0].features}, 16'h0012);
    u_drv.hdr(fis(FIS_PIO_SETUP, 1'b1, 1'b0, 8'h40, 16'h0004));
    rd_chk("held", `SSP_OFF_STATCMD, 16'h0080);
    u_drv.hdr(fis(FIS_DATA, 1'b0, 1'b0, 8'h00, 16'h0000));
    #1 chk("irq", {15'h0, intrq}, 16'h0001);
    u_drv.send(4, 16'hB000);
    rd_chk("drq", `SSP_OFF_STATCMD, 16'h0048);
    for (int i = 0; i < 4; i++)
      rd_chk("word", `SSP_OFF_DATA, 16'hB000 + 16'(i));
    rd_chk("end", `SSP_OFF_STATCMD, 16'h0080);
    u_drv.hdr(fis(FIS_DATA, 1'b1, 1'b0, 8'h40, 16'h0000));
    rd_chk("stale", `SSP_OFF_STATCMD, 16'h0080);
  endtask
  task automatic t_pio_write;
    slow <= 1'b1;
    u_drv.hdr(fis(FIS_REG_D2H, 1'b0, 1'b0, 8'h80, 16'h0000));
    u_drv.tx_q.delete();
    u_drv.hdr(fis(FIS_PIO_SETUP, 1'b1, 1'b1, 8'h40, 16'h0003));
    #1 chk("irq", {15'h0, intrq}, 16'h0001);
    rd_chk("drq", `SSP_OFF_STATCMD, 16'h0048);
    for (int i = 0; i < 3; i++)
      wr(`SSP_OFF_DATA, 16'hA000 + 16'(i));
    rd_chk("final", `SSP_OFF_STATCMD, 16'h0080);
    repeat (20) @(posedge ref_clk);
    chk("txn", 16'(u_drv.tx_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++)
    begin
      chk("tx", u_drv.tx_q[i].data, 16'hA000 + 16'(i));
      chk("last", {15'h0, u_drv.tx_q[i].last}, 16'(i == 2));
    end
    u_drv.hdr(fis(FIS_REG_D2H, 1'b1, 1'b0, 8'h40, 16'h0000));
    #1 chk("done irq", {15'h0, intrq}, 16'h0001);
    rd_chk("done", `SSP_OFF_STATCMD, 16'h0040);
    u_drv.hdr(fis(FIS_PIO_SETUP, 1'b1, 1'b1, 8'h41, 16'h0001));
    #1 chk("err irq", {15'h0, intrq}, 16'h0001);
    rd_chk("err", `SSP_OFF_STATCMD, 16'h0049);
  endtask
  task automatic t_queue;
    u_drv.hdr(fis(FIS_REG_D2H, 1'b1, 1'b0, 8'h04, 16'h0000));
    #1 chk("irq", {15'h0, intrq}, 16'h0001);
    rd_chk("rel", `SSP_OFF_STATCMD, 16'h0004);
    u_drv.hdr(fis(FIS_SDB, 1'b0, 1'b0, 8'h00, 16'h0000));
    #1 chk("sdb irq", {15'h0, intrq}, 16'h0001);
    rd_chk("service_request_flag", `SSP_OFF_STATCMD, 16'h0014);
    wr(`SSP_OFF_STATCMD, 16'h00A0);
    u_drv.hdr(fis(FIS_SDB, 1'b0, 1'b0, 8'h00, 16'h0000));
    #1 chk("busy irq", {15'h0, intrq}, 16'h0000);
    u_drv.hdr(fis(FIS_REG_D2H, 1'b1, 1'b0, 8'h08, 16'h0005));
    rd_chk("tag", `SSP_OFF_SECCNT, 16'h0005);
    rd_chk("svc", `SSP_OFF_STATCMD, 16'h0008);
  endtask
  task automatic t_dma_in;
    u_drv.hdr(fis(FIS_DATA, 1'b0, 1'b0, 8'h00, 16'h0000));
    fork
      u_drv.send(6, 16'hC000);
    join_none
    repeat (20) @(posedge ref_clk);
    #1 chk("rx hold", {15'h0, rx_data_ready}, 16'h0000);
    chk("snk idle", {15'h0, dma_snk_valid}, 16'h0000);
    dma_snk_ready <= 1'b1;
    wr(`SSP_OFF_DMA_CTRL, 16'h0001);
    repeat (30) @(posedge ref_clk);
    for (int i = 0; i < 6; i++)
      chk("dma in", snk_q[i], 16'hC000 + 16'(i));
  endtask
  task automatic t_dma_out;
    u_drv.hdr(fis(FIS_REG_D2H, 1'b0, 1'b0, 8'h80, 16'h0000));
    wr(`SSP_OFF_DMA_CTRL, 16'h0000);
    u_drv.tx_q.delete();
    u_drv.hdr(fis(FIS_DMA_ACT, 1'b0, 1'b0, 8'h00, 16'h0000));
    wr(`SSP_OFF_DMA_CNT, 16'h0006);
    wr(`SSP_OFF_DMA_CTRL, 16'h0003);
    repeat (40) @(posedge ref_clk);
    chk("frame1", 16'(u_drv.tx_q.size()), 16'h0004);
    u_drv.hdr(fis(FIS_DMA_ACT, 1'b0, 1'b0, 8'h00, 16'h0000));
    repeat (40) @(posedge ref_clk);
    chk("total", 16'(u_drv.tx_q.size()), 16'h0006);
    for (int i = 0; i < 6; i++)
    begin
      chk("dma out", u_drv.tx_q[i].data, 16'hD000 + 16'(i));
      chk("dlast", {15'h0, u_drv.tx_q[i].last}, 16'(i == 3 || i == 5));
    end
    rd_chk("left", `SSP_OFF_DMA_CNT, 16'h0000);
  endtask
  initial
  begin
    rst_n         = 1'b0;
    reg_addr      = 4'h0;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    slow          = 1'b0;
    dma_src_valid = 1'b1;
    dma_src_data  = 16'hD000;
    dma_snk_ready = 1'b0;
    error_cnt     = 0;
    n_checks      = 0;
    cyc           = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_pio_read();
    t_pio_write();
    t_queue();
    t_dma_in();
    t_dma_out();
    give_verdict();
  end
endmodule
`default_nettype wire
